// ===== rtl/csi2_merge_forwarding_output_ctl.v
`timescale 1ns/1ps
`include "merge_forward_map.vh"
`default_nettype none

module csi2_merge_forwarding_output_ctl #(
	parameter BUF_DEPTH = 2,
	parameter BUF_PTR_W = 1
) (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Register port
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_rdata_valid,
	// Device pin and receiver lock
	input wire power_down_pin,
	input wire [3:0] rx_lock,
	// Receive port buffers
	input wire [3:0] rx_pkt_valid,
	input wire [7:0] rx_pkt_kind,
	input wire [63:0] rx_pkt_wc,
	output reg [3:0] rx_pkt_pop,
	input wire [31:0] rx_byte,
	input wire [3:0] rx_byte_valid,
	output wire [3:0] rx_byte_pop,
	// Transmit byte link
	input wire tx_byte_clk,
	input wire tx_phy_ready,
	output reg [7:0] csi_data_out,
	output reg csi_byte_strobe,
	output reg csi_drive_en,
	output reg csi_hs_zero
);

	localparam ST_IDLE = 6'b000001;
	localparam ST_HDR = 6'b000010;
	localparam ST_PAY = 6'b000100;
	localparam ST_CRC = 6'b001000;
	localparam ST_END = 6'b010000;
	localparam ST_DROP = 6'b100000;

	function [1:0] low_port(input [3:0] m);
		begin
			if (m[0])
				low_port = 2'd0;
			else if (m[1])
				low_port = 2'd1;
			else if (m[2])
				low_port = 2'd2;
			else
				low_port = 2'd3;
		end
	endfunction

	function [3:0] onehot(input [1:0] p);
		onehot = 4'b0001 << p;
	endfunction

	function [1:0] kind_of(input [7:0] k, input [1:0] p);
		kind_of = k[p*2 +: 2];
	endfunction

	function [15:0] wc_of(input [63:0] v, input [1:0] p);
		wc_of = v[p*16 +: 16];
	endfunction

	function [15:0] wc_sum(input [63:0] v, input [3:0] m);
		integer i;
		begin
			wc_sum = 16'h0000;
			for (i = 0; i < 4; i = i + 1) begin
				if (m[i])
					wc_sum = wc_sum + v[i*16 +: 16];
			end
		end
	endfunction

	function [15:0] crc_step(input [15:0] c, input [7:0] d);
		integer i;
		begin
			crc_step = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (crc_step[0] ^ d[i])
					crc_step = (crc_step >> 1) ^ `CRC_POLY;
				else
					crc_step = crc_step >> 1;
			end
		end
	endfunction

	// Header bytes leave low byte first: identifier, count low, count high, code
	function [31:0] make_hdr(input [1:0] vc, input [5:0] dt, input [15:0] wc);
		reg [23:0] d;
		begin
			d = {wc, vc, dt};
			make_hdr = {2'b00, ^(d & `ECC_MASK5), ^(d & `ECC_MASK4), ^(d & `ECC_MASK3),
				^(d & `ECC_MASK2), ^(d & `ECC_MASK1), ^(d & `ECC_MASK0), d};
		end
	endfunction

	reg [7:0] general_config;
	reg [7:0] port_forward_control;
	reg [7:0] forward_mode_control;
	reg [7:0] transmit_port_select;
	reg [7:0] transmit_control;
	reg [7:0] receive_port_page_select;
	reg [7:0] dt_chan [0:3];

	reg [6:0] sync1;
	reg [6:0] sync2;
	reg byte_clk_d;

	reg [5:0] state;
	reg [1:0] cur;
	reg [3:0] pend;
	reg [3:0] grp;
	reg merged;
	reg [1:0] kind_r;
	reg [31:0] hdr;
	reg [1:0] bcnt;
	reg [15:0] rem;
	reg [15:0] crc;

	reg [7:0] buf_mem [0:BUF_DEPTH-1];
	reg [BUF_PTR_W-1:0] wr_ptr;
	reg [BUF_PTR_W-1:0] rd_ptr;
	reg [BUF_PTR_W:0] buf_count;

	wire [3:0] lock_s = sync2[3:0];
	wire awake_s = sync2[4];
	wire byte_clk_s = sync2[5];
	wire phy_ready_s = sync2[6];
	wire byte_edge = byte_clk_s & ~byte_clk_d;

	wire tx_en = transmit_control[`TC_TRANSMIT_ENABLE_BIT];
	wire sleep_sel = general_config[`GC_SLEEP_SELECT_BIT];
	wire drive_en = general_config[`GC_DRIVE_ENABLE_BIT];
	wire [3:0] mapped = ~port_forward_control[7:`PFC_MAP_LSB];
	wire [3:0] en_ports = mapped & ~port_forward_control[3:0];
	wire input_active = |(lock_s & mapped);
	wire pins_live = awake_s & sleep_sel & drive_en & input_active;

	wire mode_basic = forward_mode_control == `MODE_BASIC;
	wire mode_ilv = forward_mode_control == `MODE_INTERLEAVE;
	wire mode_cat = forward_mode_control == `MODE_CONCAT;
	wire sync_mode = mode_basic | mode_ilv | mode_cat;

	wire [3:0] rest = pend & ~onehot(cur);
	wire [7:0] cur_byte = rx_byte[cur*8 +: 8];
	wire buf_in_ready = buf_count != BUF_DEPTH;
	wire buf_out_valid = buf_count != 0;
	wire buf_pop = byte_edge & buf_out_valid & pins_live & phy_ready_s;
	wire byte_take = tx_en & state[2] & (rem != 16'h0000) & rx_byte_valid[cur] & buf_in_ready;
	wire buf_push = (tx_en & buf_in_ready & (state[1] | state[3])) | byte_take;
	wire [7:0] push_data = state[1] ? hdr[7:0] :
		state[3] ? (bcnt[0] ? crc[15:8] : crc[7:0]) : cur_byte;

	assign rx_byte_pop = byte_take ? onehot(cur) : 4'h0;

	// Start of a packet, from the idle decision or the next port of a group
	reg start_go;
	reg resync;
	reg drop_done;
	reg [1:0] start_port;
	reg [3:0] start_mask;
	reg start_merged;
	reg [1:0] start_kind;
	reg [15:0] start_wc;
	reg [5:0] start_dt;
	reg [31:0] start_hdr;
	reg [3:0] cand;
	reg [1:0] lead_kind;
	reg all_ready;
	reg mismatch;
	integer i;
	// Separate index for the register process, so each variable has one driver
	integer k;

	always @* begin
		cand = rx_pkt_valid & en_ports;
		lead_kind = kind_of(rx_pkt_kind, low_port(en_ports));
		all_ready = (en_ports != 4'h0) && ((rx_pkt_valid & en_ports) == en_ports);
		mismatch = 1'b0;
		drop_done = all_ready;
		for (i = 0; i < 4; i = i + 1) begin
			if (en_ports[i] && rx_pkt_kind[i*2 +: 2] != lead_kind)
				mismatch = 1'b1;
			if (en_ports[i] && rx_pkt_kind[i*2 +: 2] != `KIND_START)
				drop_done = 1'b0;
		end
		start_go = 1'b0;
		resync = 1'b0;
		start_port = low_port(cand);
		start_mask = onehot(low_port(cand));
		start_merged = 1'b0;
		start_kind = kind_of(rx_pkt_kind, low_port(cand));
		rx_pkt_pop = 4'h0;
		case (state)
			ST_IDLE: begin
				if (!sync_mode) begin
					start_go = cand != 4'h0;
				end else if (all_ready && !mismatch) begin
					start_go = 1'b1;
					start_port = low_port(en_ports);
					start_mask = en_ports;
					start_kind = lead_kind;
					start_merged = (lead_kind == `KIND_LINE) ? mode_cat : (mode_ilv | mode_cat);
				end else if (all_ready) begin
					resync = 1'b1;
				end
			end
			ST_END: begin
				start_go = !merged && rest != 4'h0;
				start_port = low_port(rest);
				start_mask = onehot(low_port(rest));
				start_kind = kind_r;
				// Merged groups drop the other ports' headers here
				rx_pkt_pop = tx_en ? (merged ? grp : onehot(cur)) : 4'h0;
			end
			ST_DROP: begin
				for (i = 0; i < 4; i = i + 1) begin
					if (tx_en && en_ports[i] && rx_pkt_valid[i] &&
						rx_pkt_kind[i*2 +: 2] != `KIND_START)
						rx_pkt_pop[i] = 1'b1;
				end
			end
			default: begin
				start_go = 1'b0;
			end
		endcase
		if (start_kind == `KIND_START)
			start_dt = `DT_FRAME_START;
		else if (start_kind == `KIND_END)
			start_dt = `DT_FRAME_END;
		else
			start_dt = dt_chan[start_port][5:0];
		if (start_kind != `KIND_LINE)
			start_wc = 16'h0000;
		else if (start_merged)
			start_wc = wc_sum(rx_pkt_wc, start_mask);
		else
			start_wc = wc_of(rx_pkt_wc, start_port);
		// Channel is taken per port unchecked, so concatenated sources must agree
		start_hdr = make_hdr(dt_chan[start_port][7:`DTC_VC_LSB], start_dt, start_wc);
	end

	// Registers
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			general_config <= `RST_GENERAL_CONFIG;
			port_forward_control <= `RST_PORT_FORWARD_CONTROL;
			forward_mode_control <= `RST_FORWARD_MODE_CONTROL;
			transmit_port_select <= `RST_TRANSMIT_PORT_SELECT;
			transmit_control <= `RST_TRANSMIT_CONTROL;
			receive_port_page_select <= `RST_RECEIVE_PORT_PAGE_SELECT;
			for (k = 0; k < 4; k = k + 1)
				dt_chan[k] <= `RST_RECEIVE_DATATYPE_CHANNEL;
			reg_rdata <= 8'h00;
			reg_rdata_valid <= 1'b0;
		end else begin
			reg_rdata_valid <= reg_read;
			if (reg_write) begin
				case (reg_addr)
					`ADDR_GENERAL_CONFIG: general_config <= reg_wdata;
					`ADDR_PORT_FORWARD_CONTROL: port_forward_control <= reg_wdata;
					`ADDR_FORWARD_MODE_CONTROL: forward_mode_control <= reg_wdata;
					`ADDR_TRANSMIT_PORT_SELECT: transmit_port_select <= reg_wdata;
					`ADDR_TRANSMIT_CONTROL: transmit_control <= {1'b0, reg_wdata[6:0]};
					`ADDR_RECEIVE_PORT_PAGE_SELECT: receive_port_page_select <= reg_wdata;
					`ADDR_RECEIVE_DATATYPE_CHANNEL: begin
						// One write may land on several ports at once
						for (k = 0; k < 4; k = k + 1) begin
							if (receive_port_page_select[k])
								dt_chan[k] <= reg_wdata;
						end
					end
					default: begin
					end
				endcase
			end
			if (reg_read) begin
				case (reg_addr)
					`ADDR_GENERAL_CONFIG: reg_rdata <= general_config;
					`ADDR_PORT_FORWARD_CONTROL: reg_rdata <= port_forward_control;
					`ADDR_FORWARD_MODE_CONTROL: reg_rdata <= forward_mode_control;
					`ADDR_TRANSMIT_PORT_SELECT: reg_rdata <= transmit_port_select;
					`ADDR_TRANSMIT_CONTROL: reg_rdata <= {pins_live, transmit_control[6:0]};
					`ADDR_RECEIVE_PORT_PAGE_SELECT: reg_rdata <= receive_port_page_select;
					`ADDR_RECEIVE_DATATYPE_CHANNEL:
						reg_rdata <= dt_chan[receive_port_page_select[5:`PAGE_READ_LSB]];
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Packet sequencer; stalls in place while the transmitter is disabled
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			cur <= 2'd0;
			pend <= 4'h0;
			grp <= 4'h0;
			merged <= 1'b0;
			kind_r <= `KIND_LINE;
			hdr <= 32'h00000000;
			bcnt <= 2'd0;
			rem <= 16'h0000;
			crc <= `CRC_INIT;
		end else if (tx_en) begin
			case (state)
				ST_IDLE: begin
					if (start_go) begin
						cur <= start_port;
						pend <= start_mask;
						grp <= start_mask;
						merged <= start_merged;
						kind_r <= start_kind;
						hdr <= start_hdr;
						bcnt <= 2'd0;
						crc <= `CRC_INIT;
						state <= ST_HDR;
					end else if (resync) begin
						state <= ST_DROP;
					end
				end
				ST_HDR: begin
					if (buf_in_ready) begin
						hdr <= {8'h00, hdr[31:8]};
						bcnt <= bcnt + 2'd1;
						if (bcnt == 2'd3) begin
							rem <= wc_of(rx_pkt_wc, cur);
							state <= (kind_r == `KIND_LINE) ? ST_PAY : ST_END;
						end
					end
				end
				ST_PAY: begin
					if (rem == 16'h0000) begin
						if (merged && rest != 4'h0) begin
							// Next segment follows directly, no fill bytes
							cur <= low_port(rest);
							pend <= rest;
							rem <= wc_of(rx_pkt_wc, low_port(rest));
						end else begin
							bcnt <= 2'd0;
							state <= ST_CRC;
						end
					end else if (byte_take) begin
						crc <= crc_step(crc, cur_byte);
						rem <= rem - 16'h0001;
					end
				end
				ST_CRC: begin
					if (buf_in_ready) begin
						bcnt <= bcnt + 2'd1;
						if (bcnt[0])
							state <= ST_END;
					end
				end
				ST_END: begin
					pend <= rest;
					if (start_go) begin
						cur <= start_port;
						hdr <= start_hdr;
						bcnt <= 2'd0;
						crc <= `CRC_INIT;
						state <= ST_HDR;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_DROP: begin
					if (drop_done)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Two-entry buffer toward the byte link
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= {BUF_PTR_W{1'b0}};
			rd_ptr <= {BUF_PTR_W{1'b0}};
			buf_count <= {(BUF_PTR_W+1){1'b0}};
		end else begin
			if (buf_push) begin
				buf_mem[wr_ptr] <= push_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (buf_pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (buf_push && !buf_pop)
				buf_count <= buf_count + 1'b1;
			else if (buf_pop && !buf_push)
				buf_count <= buf_count - 1'b1;
		end
	end

	// Link side: byte clock and pins are sampled, never used as clocks
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
			byte_clk_d <= 1'b0;
			csi_data_out <= 8'h00;
			csi_byte_strobe <= 1'b0;
			csi_drive_en <= 1'b0;
			csi_hs_zero <= 1'b0;
		end else begin
			sync1 <= {tx_phy_ready, tx_byte_clk, power_down_pin, rx_lock};
			sync2 <= sync1;
			byte_clk_d <= byte_clk_s;
			csi_byte_strobe <= buf_pop;
			if (buf_pop)
				csi_data_out <= buf_mem[rd_ptr];
			else if (!pins_live)
				csi_data_out <= 8'h00;
			csi_drive_en <= awake_s & (~sleep_sel | (drive_en & input_active));
			csi_hs_zero <= awake_s & ~sleep_sel;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/merge_forward_map.vh
`ifndef MERGE_FORWARD_MAP_VH
`define MERGE_FORWARD_MAP_VH

// Register offsets
`define ADDR_GENERAL_CONFIG 8'h02
`define ADDR_PORT_FORWARD_CONTROL 8'h20
`define ADDR_FORWARD_MODE_CONTROL 8'h21
`define ADDR_TRANSMIT_PORT_SELECT 8'h32
`define ADDR_TRANSMIT_CONTROL 8'h33
`define ADDR_RECEIVE_PORT_PAGE_SELECT 8'h4c
`define ADDR_RECEIVE_DATATYPE_CHANNEL 8'h70

// Reset values
`define RST_GENERAL_CONFIG 8'h03
`define RST_PORT_FORWARD_CONTROL 8'h0f
`define RST_FORWARD_MODE_CONTROL 8'h00
`define RST_TRANSMIT_PORT_SELECT 8'h00
`define RST_TRANSMIT_CONTROL 8'h00
`define RST_RECEIVE_PORT_PAGE_SELECT 8'h00
`define RST_RECEIVE_DATATYPE_CHANNEL 8'h00

// Field positions
`define GC_DRIVE_ENABLE_BIT 0
`define GC_SLEEP_SELECT_BIT 1
`define TC_TRANSMIT_ENABLE_BIT 0
`define TC_STATUS_BIT 7
`define PFC_MAP_LSB 4
`define PAGE_READ_LSB 4
`define DTC_VC_LSB 6

// Synchronized forwarding mode codes
`define MODE_BASIC 8'h14
`define MODE_INTERLEAVE 8'h28
`define MODE_CONCAT 8'h3c

// Buffered packet kinds
`define KIND_LINE 2'h0
`define KIND_START 2'h1
`define KIND_END 2'h2

// Short packet data types
`define DT_FRAME_START 6'h00
`define DT_FRAME_END 6'h01

// Packet checksum and header code
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define ECC_MASK0 24'hf12cb7
`define ECC_MASK1 24'hf2555b
`define ECC_MASK2 24'h749a6d
`define ECC_MASK3 24'hb8e38e
`define ECC_MASK4 24'hdf03f0
`define ECC_MASK5 24'heffc00

`endif

// ===== testbench/csi_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module csi_sink_model (
	// Clock and control
	input wire logic ref_clk,
	input wire logic stall,
	// Link from the block
	input wire logic [7:0] csi_data_out,
	input wire logic csi_byte_strobe,
	output logic tx_byte_clk,
	output logic tx_phy_ready
);
	logic [7:0] got[$];
	logic [2:0] cnt;
	// PHY byte clock runs free, phase unrelated to ref_clk
	initial begin
		tx_byte_clk = 1'b0;
		tx_phy_ready = 1'b1;
		cnt = 3'h0;
		#13;
		forever #40 tx_byte_clk = ~tx_byte_clk;
	end
	// Half-time stall forces the output buffer to hold bytes
	always @(posedge tx_byte_clk) begin
		cnt <= cnt + 3'h1;
		tx_phy_ready <= !(stall && cnt[1]);
	end
	// Kept in arrival order; images are told apart by position only
	always @(posedge ref_clk) begin
		if (csi_byte_strobe)
			got.push_back(csi_data_out);
	end
endmodule
`default_nettype wire

// ===== testbench/merge_fwd_chk_chk.sv
`timescale 1ns/1ps
`default_nettype none
module merge_fwd_chk (
	// Clock, reset and registers
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rdata_valid,
	// Pins and buffers
	input wire logic power_down_pin,
	input wire logic [3:0] rx_lock,
	input wire logic [3:0] rx_pkt_valid,
	input wire logic [3:0] rx_pkt_pop,
	input wire logic [3:0] rx_byte_valid,
	input wire logic [3:0] rx_byte_pop,
	// Output link
	input wire logic [7:0] csi_data_out,
	input wire logic csi_byte_strobe,
	input wire logic csi_drive_en,
	input wire logic csi_hs_zero
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_mode_wr;
		reg_write && reg_addr == 8'h21 ##1 reg_read && reg_addr == 8'h21;
	endsequence
	sequence s_pd_low;
		(!power_down_pin) [*5];
	endsequence
	property p_mode_back;
		s_mode_wr |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_mode_back: assert property (p_mode_back) else $error("mode readback wrong");
	property p_read_pulse;
		reg_read |=> reg_rdata_valid;
	endproperty
	a_read_pulse: assert property (p_read_pulse) else $error("no read answer");
	property p_no_read;
		!reg_read |=> !reg_rdata_valid;
	endproperty
	a_no_read: assert property (p_no_read) else $error("spurious read answer");
	property p_pd_float;
		s_pd_low |-> !csi_drive_en && !csi_hs_zero;
	endproperty
	a_pd_float: assert property (p_pd_float) else $error("pins driven in power-down");
	property p_sleep_data;
		csi_hs_zero |-> csi_data_out == 8'h00 && !csi_byte_strobe;
	endproperty
	a_sleep_data: assert property (p_sleep_data) else $error("data during HS-0");
	property p_strobe_live;
		csi_byte_strobe |-> csi_drive_en && !csi_hs_zero;
	endproperty
	a_strobe_live: assert property (p_strobe_live) else $error("byte on dead pins");
	property p_lock_gate;
		(rx_lock == 4'h0) [*5] |-> !csi_drive_en || csi_hs_zero;
	endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("live without lock");
	property p_pop_valid;
		((rx_pkt_pop & ~rx_pkt_valid) | (rx_byte_pop & ~rx_byte_valid)) == 4'h0;
	endproperty
	a_pop_valid: assert property (p_pop_valid) else $error("pop of absent entry");
	property p_strobe_gap;
		csi_byte_strobe |=> (!csi_byte_strobe) [*8];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("bytes too close");
endmodule
`default_nettype wire

// ===== testbench/test_csi2_merge_forwarding_output_ctl.sv
`timescale 1ns/1ps
`include "merge_forward_map.vh"
`default_nettype none
module test_csi2_merge_forwarding_output_ctl;
	logic ref_clk, resetn, reg_write, reg_read, reg_rdata_valid, power_down_pin;
	logic stall, ld, tx_byte_clk, tx_phy_ready, csi_byte_strobe, csi_drive_en, csi_hs_zero;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, csi_data_out, rx_pkt_kind, q;
	logic [3:0] rx_lock, rx_pkt_valid, rx_pkt_pop, rx_byte_valid, rx_byte_pop, pp, bp;
	logic [63:0] rx_pkt_wc;
	logic [31:0] rx_byte;
	logic [7:0] exp_q[$];
	// Port 0 starts a new frame after its frame end, to recover from a skew
	bit wrap;
	int pi[4], bi[4], mismatches, n_checks, cyc;

	csi2_merge_forwarding_output_ctl i_dut (
		.ref_clk(ref_clk), .resetn(resetn),
		.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
		.power_down_pin(power_down_pin), .rx_lock(rx_lock),
		.rx_pkt_valid(rx_pkt_valid), .rx_pkt_kind(rx_pkt_kind), .rx_pkt_wc(rx_pkt_wc),
		.rx_pkt_pop(rx_pkt_pop), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
		.rx_byte_pop(rx_byte_pop), .tx_byte_clk(tx_byte_clk), .tx_phy_ready(tx_phy_ready),
		.csi_data_out(csi_data_out), .csi_byte_strobe(csi_byte_strobe),
		.csi_drive_en(csi_drive_en), .csi_hs_zero(csi_hs_zero)
	);
	csi_sink_model i_sink (
		.ref_clk(ref_clk), .stall(stall), .csi_data_out(csi_data_out),
		.csi_byte_strobe(csi_byte_strobe), .tx_byte_clk(tx_byte_clk),
		.tx_phy_ready(tx_phy_ready)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic logic [7:0] bv(int i, int p, int b);
		return 8'(16 * i + 4 * p + b);
	endfunction

	// Port buffer: frame start, two lines of two bytes, frame end
	task drive_bufs;
		for (int i = 0; i < 4; i++) begin
			rx_pkt_valid[i] = ld && pi[i] < 4;
			rx_pkt_kind[2*i+:2] = pi[i] == 0 ? 2'h1 : pi[i] == 3 ? 2'h2 : 2'h0;
			rx_pkt_wc[16*i+:16] = (pi[i] == 1 || pi[i] == 2) ? 16'h0002 : 16'h0000;
			rx_byte_valid[i] = rx_pkt_valid[i] && rx_pkt_wc[16*i+1] && bi[i] < 2;
			rx_byte[8*i+:8] = bv(i, pi[i], bi[i]);
		end
	endtask

	// Pops are settled mid-cycle; applied just after the edge
	always @(negedge ref_clk) begin
		pp = rx_pkt_pop;
		bp = rx_byte_pop;
	end
	always @(posedge ref_clk) begin
		#1;
		if (|{pp, bp}) begin
			for (int i = 0; i < 4; i++) begin
				if (pp[i]) begin
					pi[i] = (wrap && i == 0 && pi[i] == 3) ? 0 : pi[i] + 1;
					bi[i] = 0;
				end else if (bp[i])
					bi[i]++;
			end
			drive_bufs;
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge ref_clk); #1;
		reg_write = 1'b0;
		reg_read = 1'b1;
		@(posedge ref_clk); #1;
		reg_read = 1'b0;
		r = reg_rdata;
		@(posedge ref_clk); #1;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] r);
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge ref_clk); #1;
		reg_read = 1'b0;
		r = reg_rdata;
		@(posedge ref_clk); #1;
	endtask

	task t_regs;
		logic [7:0] ad[7];
		logic [7:0] rv[7];
		ad = '{`ADDR_GENERAL_CONFIG, `ADDR_PORT_FORWARD_CONTROL, `ADDR_FORWARD_MODE_CONTROL,
			`ADDR_TRANSMIT_PORT_SELECT, `ADDR_TRANSMIT_CONTROL, `ADDR_RECEIVE_PORT_PAGE_SELECT,
			`ADDR_RECEIVE_DATATYPE_CHANNEL};
		rv = '{`RST_GENERAL_CONFIG, `RST_PORT_FORWARD_CONTROL, `RST_FORWARD_MODE_CONTROL,
			`RST_TRANSMIT_PORT_SELECT, `RST_TRANSMIT_CONTROL, `RST_RECEIVE_PORT_PAGE_SELECT,
			`RST_RECEIVE_DATATYPE_CHANNEL};
		for (int k = 0; k < 7; k++) begin
			rd(ad[k], q);
			chk(16'(q), 16'(rv[k]));
		end
		rd(8'h55, q);
		chk(16'(q), 16'h0000);
		// Status bit must not take the written one while pins are dead
		wrd(8'h33, 8'h81, q);
		chk(16'(q), 16'h0001);
		for (int p = 0; p < 4; p++) begin
			wrd(8'h4c, p == 0 ? 8'h01 : {2'b00, 2'(p), 4'(1 << p)}, q);
			wrd(8'h70, {2'(p), 6'h1f}, q);
			chk(16'(q), {8'h00, 2'(p), 6'h1f});
		end
	endtask

	task t_pins;
		logic [5:0] row[5];
		row = '{6'b011100, 6'b101111, 6'b110100, 6'b111000, 6'b111110};
		for (int k = 0; k < 5; k++) begin
			power_down_pin = row[k][5];
			rx_lock = row[k][2] ? 4'h8 : 4'h0;
			wrd(8'h02, {6'h00, row[k][4:3]}, q);
			repeat (8) @(posedge ref_clk);
			#1;
			chk({14'h0, csi_drive_en, csi_hs_zero}, {14'h0, row[k][1:0]});
		end
		rd(8'h33, q);
		chk(16'(q), 16'h0081);
		rx_lock = 4'hf;
	endtask

	task automatic pkt(input logic [7:0] di, input logic [3:0] m, input int l);
		logic [7:0] pl[$];
		logic [15:0] c;
		logic [23:0] h;
		for (int p = 0; p < 4; p++)
			if (m[p])
				for (int b = 0; b < 2; b++)
					pl.push_back(bv(p, l, b));
		h = {16'(pl.size()), di};
		exp_q.push_back(di);
		exp_q.push_back(h[15:8]);
		exp_q.push_back(h[23:16]);
		exp_q.push_back({2'b00, ^(h & `ECC_MASK5), ^(h & `ECC_MASK4), ^(h & `ECC_MASK3),
			^(h & `ECC_MASK2), ^(h & `ECC_MASK1), ^(h & `ECC_MASK0)});
		if (m != 4'h0) begin
			c = 16'hffff;
			foreach (pl[k]) begin
				exp_q.push_back(pl[k]);
				for (int j = 0; j < 8; j++)
					c = (c >> 1) ^ ((c[0] ^ pl[k][j]) ? 16'h8408 : 16'h0000);
			end
			exp_q.push_back(c[7:0]);
			exp_q.push_back(c[15:8]);
		end
	endtask

	task t_mode(input logic [7:0] mode, input logic [7:0] fwd, input int p0);
		int n;
		int lo;
		logic [3:0] en;
		en = ~fwd[3:0];
		lo = fwd[0] ? 1 : 0;
		exp_q = {};
		i_sink.got = {};
		wrd(8'h20, 8'h0f, q);
		wrd(8'h21, mode, q);
		chk(16'(q), 16'(mode));
		case (mode)
			8'h14: begin
				for (int p = 0; p < 4; p++) pkt({2'(p), 6'h00}, 4'h0, 0);
				for (int l = 1; l < 3; l++)
					for (int p = 0; p < 4; p++) pkt({2'(p), 6'h1f}, 4'(1 << p), l);
				for (int p = 0; p < 4; p++) pkt({2'(p), 6'h01}, 4'h0, 0);
			end
			8'h28: begin
				pkt({2'(lo), 6'h00}, 4'h0, 0);
				for (int l = 1; l < 3; l++)
					for (int p = 0; p < 4; p++) pkt({2'(p), 6'h1f}, 4'(1 << p), l);
				pkt({2'(lo), 6'h01}, 4'h0, 0);
			end
			default: begin
				pkt({2'(lo), 6'h00}, 4'h0, 0);
				for (int l = 1; l < 3; l++) pkt({2'(lo), 6'h1f}, en, l);
				pkt({2'(lo), 6'h01}, 4'h0, 0);
			end
		endcase
		for (int i = 0; i < 4; i++) begin
			pi[i] = 0;
			bi[i] = 0;
		end
		// Skewed port 0 forces a resync that drops its stale packets
		pi[0] = p0;
		wrap = p0 != 0;
		ld = 1'b1;
		drive_bufs;
		wrd(8'h20, fwd, q);
		n = 0;
		while (i_sink.got.size() < exp_q.size() && n < 8000) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (100) @(posedge ref_clk);
		#1;
		chk(16'(i_sink.got.size()), 16'(exp_q.size()));
		foreach (exp_q[k]) chk(16'(i_sink.got[k]), 16'(exp_q[k]));
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			end_sim;
		end
	end

	initial begin
		resetn = 1'b0;
		{reg_write, reg_read, reg_addr, reg_wdata, stall, ld, pp, bp} = '0;
		power_down_pin = 1'b1;
		rx_lock = 4'h0;
		{mismatches, n_checks, cyc} = '0;
		for (int i = 0; i < 4; i++) begin
			pi[i] = 0;
			bi[i] = 0;
		end
		drive_bufs;
		repeat (16) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		@(posedge ref_clk); #1;
		t_regs;
		t_pins;
		t_mode(8'h14, 8'h00, 0);
		t_mode(8'h28, 8'h00, 0);
		t_mode(8'h14, 8'h00, 3);
		t_mode(8'h00, 8'h0e, 0);
		stall = 1'b1;
		t_mode(8'h3c, 8'h01, 0);
		end_sim;
	end
endmodule

bind csi2_merge_forwarding_output_ctl merge_fwd_chk i_chk (
	.ref_clk(ref_clk), .resetn(resetn), .reg_write(reg_write), .reg_read(reg_read),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rdata_valid(reg_rdata_valid), .power_down_pin(power_down_pin), .rx_lock(rx_lock),
	.rx_pkt_valid(rx_pkt_valid), .rx_pkt_pop(rx_pkt_pop), .rx_byte_valid(rx_byte_valid),
	.rx_byte_pop(rx_byte_pop), .csi_data_out(csi_data_out),
	.csi_byte_strobe(csi_byte_strobe), .csi_drive_en(csi_drive_en), .csi_hs_zero(csi_hs_zero)
);
`default_nettype wire
